// File: hdl/byte_rotate_pkg.sv
// Shared types and constants for the byte rotate datapath.
// Assumes an 8-bit core that decodes rotate instructions and supplies the memory operand.
package byte_rotate_pkg;

   localparam int DATA_W = 8;
   localparam int MSB = 7;
   localparam int LSB = 0;
   localparam logic [DATA_W-1:0] WREG_RST = 8'h00;
   localparam logic CARRY_RST = 1'h0;

   typedef enum logic [2:0] {
      rotate_left_to_working_reg,
      rotate_left_through_carry,
      rotate_left_carry_to_working_reg,
      rotate_right_in_place,
      rotate_right_to_working_reg
   } rot_op_t;

   // One decoded rotate instruction with its memory operand
   typedef struct packed {
      logic valid;
      rot_op_t op;
      logic [DATA_W-1:0] mem_byte;
   } rot_req_t;

   // Where a result goes and what it does to carry
   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic carry_out;
      logic to_mem;
      logic to_wreg;
      logic carry_upd;
   } rot_res_t;

   // Core register loads from outside this block
   typedef struct packed {
      logic wreg_load;
      logic [DATA_W-1:0] wreg_value;
      logic carry_load;
      logic carry_value;
   } core_load_t;

endpackage : byte_rotate_pkg

// File: hdl/rotate_datapath.sv
// Combinational rotate network: result byte, new carry and destination controls.
// Assumes the caller registers the outputs and owns the working register and carry.
`timescale 1ns/1ps
module rotate_datapath
   import byte_rotate_pkg::*;
(
   // Operation
   input wire rot_op_t op_i,
   input wire logic [DATA_W-1:0] mem_byte_i,
   input wire logic carry_i,
   // Result
   output rot_res_t res_o
);

   function automatic logic [DATA_W-1:0] rot_left(input logic [DATA_W-1:0] v, input logic fill);
      rot_left = {v[MSB-1:LSB], fill};
   endfunction : rot_left

   function automatic logic [DATA_W-1:0] rot_right(input logic [DATA_W-1:0] v, input logic fill);
      rot_right = {fill, v[MSB:LSB+1]};
   endfunction : rot_right

   wire logic [DATA_W-1:0] left_wrap = rot_left(mem_byte_i, mem_byte_i[MSB]);
   wire logic [DATA_W-1:0] left_carry = rot_left(mem_byte_i, carry_i);
   wire logic [DATA_W-1:0] right_wrap = rot_right(mem_byte_i, mem_byte_i[LSB]);

   always_comb begin
      res_o = '0;
      res_o.carry_out = carry_i;
      unique case (op_i)
         rotate_left_to_working_reg: begin
            res_o.data = left_wrap;
            res_o.to_wreg = 1'b1;
         end
         rotate_left_through_carry: begin
            res_o.data = left_carry;
            res_o.carry_out = mem_byte_i[MSB];
            res_o.carry_upd = 1'b1;
            res_o.to_mem = 1'b1;
         end
         rotate_left_carry_to_working_reg: begin
            res_o.data = left_carry;
            res_o.carry_out = mem_byte_i[MSB];
            res_o.carry_upd = 1'b1;
            res_o.to_wreg = 1'b1;
         end
         rotate_right_in_place: begin
            res_o.data = right_wrap;
            res_o.to_mem = 1'b1;
         end
         rotate_right_to_working_reg: begin
            // Carry stays as it is; only the byte turns round
            res_o.data = right_wrap;
            res_o.to_wreg = 1'b1;
         end
         default: begin
            res_o.data = mem_byte_i;
         end
      endcase
   end

endmodule : rotate_datapath

// File: hdl/byte_rotate_unit.sv
// Rotate execution unit: holds the working register and carry flag, writes memory results back.
// Assumes the core presents one decoded rotate per cycle with its memory byte already fetched.
// How it works
// - Rotate memory left, wrap, into working register
// - Nine-bit left rotate through carry, back to memory
// - Nine-bit left rotate through carry into working register
// - Rotate memory right with wrap, back to memory
// - Rotate memory right with wrap into working register
`timescale 1ns/1ps
module byte_rotate_unit
   import byte_rotate_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Decoded rotate request
   input wire rot_req_t req_i,
   // Loads of working register and carry by other instructions
   input wire core_load_t load_i,
   // Core state
   output logic [DATA_W-1:0] working_register_o,
   output logic carry_o,
   // Memory write-back
   output logic mem_we_o,
   output logic [DATA_W-1:0] mem_wdata_o,
   // Completion
   output logic done_o
);

   // Core state and registered outputs
   logic [DATA_W-1:0] working_register;
   logic carry;
   logic mem_we;
   logic [DATA_W-1:0] mem_wdata;
   logic done;
   rot_res_t res;

   rotate_datapath u_rotate_datapath (
      .op_i(req_i.op),
      .mem_byte_i(req_i.mem_byte),
      .carry_i(carry),
      .res_o(res)
   );

   // A rotate in the same cycle as an outside load wins, as it is the newer instruction
   wire logic do_rot = req_i.valid;
   wire logic wreg_from_rot = do_rot && res.to_wreg;
   wire logic carry_from_rot = do_rot && res.carry_upd;
   wire logic wreg_from_load = !do_rot && load_i.wreg_load;
   wire logic carry_from_load = !do_rot && load_i.carry_load;
   wire logic mem_from_rot = do_rot && res.to_mem;

   // Rotate first, then outside load, else hold; the carry read is this cycle's flag
   wire logic [DATA_W-1:0] next_working_register =
      wreg_from_rot ? res.data : (wreg_from_load ? load_i.wreg_value : working_register);
   wire logic next_carry =
      carry_from_rot ? res.carry_out : (carry_from_load ? load_i.carry_value : carry);
   wire logic [DATA_W-1:0] next_mem_wdata = mem_from_rot ? res.data : mem_wdata;

   // Working register and carry live here so that back-to-back carry rotates chain
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         working_register <= WREG_RST;
         carry <= CARRY_RST;
      end else begin
         working_register <= next_working_register;
         carry <= next_carry;
      end
   end

   // Memory is only written for in-place forms; the others leave the operand untouched
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mem_we <= 1'b0;
         mem_wdata <= WREG_RST;
         done <= 1'b0;
      end else begin
         mem_we <= mem_from_rot;
         mem_wdata <= next_mem_wdata;
         done <= do_rot;
      end
   end

   // Every output comes straight from a flip-flop
   assign working_register_o = working_register;
   assign carry_o = carry;
   assign mem_we_o = mem_we;
   assign mem_wdata_o = mem_wdata;
   assign done_o = done;

   // Checks
   // Each request kind has its own qualifier so that every property reads like its rule
   wire logic [DATA_W-1:0] mem_byte = req_i.mem_byte;
   wire logic left_wreg_req = req_i.valid && req_i.op == rotate_left_to_working_reg;
   wire logic left_carry_mem_req = req_i.valid && req_i.op == rotate_left_through_carry;
   wire logic left_carry_wreg_req = req_i.valid && req_i.op == rotate_left_carry_to_working_reg;
   wire logic right_mem_req = req_i.valid && req_i.op == rotate_right_in_place;
   wire logic right_wreg_req = req_i.valid && req_i.op == rotate_right_to_working_reg;
   wire logic wreg_form_req = left_wreg_req || left_carry_wreg_req || right_wreg_req;
   wire logic mem_form_req = left_carry_mem_req || right_mem_req;
   wire logic illegal_req = req_i.valid && !wreg_form_req && !mem_form_req;
   // Loads only count in cycles without a rotate
   wire logic wreg_load_only = !req_i.valid && load_i.wreg_load;
   wire logic carry_load_only = !req_i.valid && load_i.carry_load;
   wire logic wreg_idle = !req_i.valid && !load_i.wreg_load;
   wire logic carry_idle = !req_i.valid && !load_i.carry_load;
   wire logic carry_keep_req = req_i.valid && !left_carry_mem_req && !left_carry_wreg_req;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // Expected bits are rebuilt from the operand, never taken from the datapath result
   a_left_wrap_wreg: assert property (
      left_wreg_req |=>
         working_register_o == {$past(mem_byte[MSB-1:LSB]), $past(mem_byte[MSB])}
         && carry_o == $past(carry_o)
         && !mem_we_o)
      else $error("left rotate into working register wrong");

   a_carry_mem_write: assert property (
      left_carry_mem_req |=>
         mem_we_o
         && mem_wdata_o == {$past(mem_byte[MSB-1:LSB]), $past(carry_o)}
         && carry_o == $past(mem_byte[MSB]))
      else $error("left rotate through carry write-back wrong");

   a_inplace_wreg_kept: assert property (
      left_carry_mem_req |=> $stable(working_register_o))
      else $error("in-place rotate disturbed working register");

   a_carry_wreg_load: assert property (
      left_carry_wreg_req |=>
         working_register_o == {$past(mem_byte[MSB-1:LSB]), $past(carry_o)}
         && carry_o == $past(mem_byte[MSB])
         && !mem_we_o)
      else $error("left rotate through carry into working register wrong");

   a_right_in_place: assert property (
      right_mem_req |=>
         mem_we_o
         && mem_wdata_o == {$past(mem_byte[LSB]), $past(mem_byte[MSB:LSB+1])}
         && $stable(carry_o)
         && $stable(working_register_o))
      else $error("right rotate in place wrong");

   a_right_wrap_wreg: assert property (
      right_wreg_req |=>
         working_register_o == {$past(mem_byte[LSB]), $past(mem_byte[MSB:LSB+1])}
         && !mem_we_o)
      else $error("right rotate into working register wrong");

   a_right_carry_kept: assert property (
      right_wreg_req |=> carry_o == $past(carry_o))
      else $error("right rotate into working register changed carry");

   a_operand_kept: assert property (
      wreg_form_req |=> !mem_we_o && $stable(mem_wdata_o))
      else $error("working register form touched memory");

   // A rotate that leaves carry alone also blocks an outside carry load
   a_carry_untouched: assert property (
      carry_keep_req |=> $stable(carry_o))
      else $error("rotate without carry changed carry");

   // Write strobe and completion pulse
   a_we_cause: assert property (
      mem_we_o |->
         $past(left_carry_mem_req || right_mem_req) && done_o)
      else $error("memory write without in-place rotate");

   a_done_pulse: assert property (
      req_i.valid |=> done_o)
      else $error("request without completion pulse");

   a_done_cause: assert property (
      done_o |-> $past(req_i.valid))
      else $error("completion pulse without request");

   // The write-back byte only moves together with its strobe
   a_wdata_hold: assert property (
      !mem_we_o |-> $stable(mem_wdata_o))
      else $error("write-back byte moved without strobe");

   // Undefined codes must leave all core state alone
   a_illegal_quiet: assert property (
      illegal_req |=>
         $stable(working_register_o)
         && $stable(carry_o)
         && !mem_we_o)
      else $error("undefined rotate code changed state");

   // Loads from other instructions; a rotate in the same cycle suppresses them
   a_wreg_load_taken: assert property (
      wreg_load_only |=> working_register_o == $past(load_i.wreg_value))
      else $error("working register load lost");

   a_carry_load_taken: assert property (
      carry_load_only |=> carry_o == $past(load_i.carry_value))
      else $error("carry load lost");

   a_rotate_beats_load: assert property (
      (mem_form_req || illegal_req) && load_i.wreg_load |=> $stable(working_register_o))
      else $error("load overrode rotate");

   a_wreg_idle_hold: assert property (
      wreg_idle |=> $stable(working_register_o))
      else $error("working register changed while idle");

   a_carry_idle_hold: assert property (
      carry_idle |=> $stable(carry_o))
      else $error("carry changed while idle");

   a_wreg_change_cause: assert property (
      !$stable(working_register_o) |-> $past(wreg_form_req || wreg_load_only))
      else $error("working register changed without cause");

   // Scenarios worth seeing at least once
   c_carry_chain: cover property (left_carry_mem_req ##1 left_carry_mem_req);
   c_carry_set: cover property (left_carry_wreg_req && mem_byte[MSB] ##1 carry_o);
   c_right_then_wreg: cover property (right_mem_req ##1 right_wreg_req);
   c_rotate_over_load: cover property (req_i.valid && load_i.wreg_load);
   c_illegal_code: cover property (illegal_req);

endmodule : byte_rotate_unit

// File: verification/byte_rotate_unit_bench.sv
// Self-checking bench for the rotate unit: a driver keeps a reference of the core state
// and queues expected results; a monitor checks them on each done pulse.
// Assumes the unit answers every valid request exactly one cycle later.
`timescale 1ns/1ps
module byte_rotate_unit_bench;
   import byte_rotate_pkg::*;
   typedef struct packed {logic [7:0] wreg; logic c; logic we; logic [7:0] wd;} note_t;
   logic clk_i;
   logic rst_n_i;
   rot_req_t req_i;
   core_load_t load_i;
   logic [DATA_W-1:0] working_register_o;
   logic [DATA_W-1:0] mem_wdata_o;
   logic carry_o;
   logic mem_we_o;
   logic done_o;
   note_t q[$];
   note_t pend;
   note_t n;
   logic has_pend;
   logic [7:0] m_w;
   logic [7:0] m_d;
   logic m_c;
   int fail_count;
   int n_checks;
   integer seed;
   logic [31:0] rnd;

   byte_rotate_unit uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .load_i(load_i),
      .working_register_o(working_register_o), .carry_o(carry_o), .mem_we_o(mem_we_o),
      .mem_wdata_o(mem_wdata_o), .done_o(done_o));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk8

   task chk1(input string what, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask : chk1

   task final_report;
      $display("checks %0d errors %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : final_report

   // The note of a request is queued at the edge that takes it, so the monitor never
   // mistakes a fresh request for a late answer.
   task issue(input logic [2:0] op, input logic [7:0] b, input logic v, input core_load_t ld);
      logic we;
      @(posedge clk_i);
      if (has_pend) q.push_back(pend);
      has_pend = 1'b0;
      #1;
      req_i = '{valid: v, op: rot_op_t'(op), mem_byte: b};
      load_i = ld;
      we = 1'b0;
      if (v) begin
         case (op)
            3'd0: m_w = {b[6:0], b[7]};
            3'd1: begin m_d = {b[6:0], m_c}; m_c = b[7]; we = 1'b1; end
            3'd2: begin m_w = {b[6:0], m_c}; m_c = b[7]; end
            3'd3: begin m_d = {b[0], b[7:1]}; we = 1'b1; end
            3'd4: m_w = {b[0], b[7:1]};
            default: ;
         endcase
         pend = '{m_w, m_c, we, m_d};
         has_pend = 1'b1;
      end else begin
         if (ld.wreg_load) m_w = ld.wreg_value;
         if (ld.carry_load) m_c = ld.carry_value;
      end
   endtask : issue

   always @(negedge clk_i) if (rst_n_i === 1'b1) begin
      if (done_o === 1'b1 && q.size() != 0) begin
         n = q.pop_front();
         chk8("working_register_o", n.wreg, working_register_o);
         chk1("carry_o", n.c, carry_o);
         chk1("mem_we_o", n.we, mem_we_o);
         chk8("mem_wdata_o", n.wd, mem_wdata_o);
      end else if (done_o !== 1'b0 || mem_we_o !== 1'b0 || q.size() != 0) begin
         chk1("done_o", q.size() != 0, done_o);
         chk1("mem_we_o idle", 1'b0, mem_we_o);
         q.delete();
      end
   end

   initial begin
      #200000;
      fail_count++;
      final_report();
   end

   initial begin
      seed = 32'hE980;
      fail_count = 0;
      n_checks = 0;
      rst_n_i = 1'b0;
      req_i = '0;
      load_i = '0;
      m_w = WREG_RST;
      m_c = CARRY_RST;
      m_d = 8'h00;
      has_pend = 1'b0;
      repeat (10) @(posedge clk_i);
      #1 rst_n_i = 1'b1;
      chk8("working_register_o", WREG_RST, working_register_o);
      chk1("carry_o", CARRY_RST, carry_o);
      chk8("mem_wdata_o", 8'h00, mem_wdata_o);
      chk1("mem_we_o", 1'b0, mem_we_o);
      chk1("done_o", 1'b0, done_o);
      // Every code once, illegal ones too, back to back on one byte
      for (int k = 0; k < 8; k++) issue(k[2:0], 8'h81, 1'b1, '0);
      repeat (600) begin
         rnd = $random(seed);
         issue(rnd[2:0], rnd[10:3], rnd[12:11] != 2'h0, core_load_t'(rnd[23:13]));
      end
      issue(3'd0, 8'h00, 1'b0, '0);
      issue(3'd0, 8'h00, 1'b0, '0);
      repeat (3) @(posedge clk_i);
      final_report();
   end
endmodule : byte_rotate_unit_bench
